// file: rtl/frp_pkg.sv
// Purpose: constants and types for the fault response policy block
// Assumes: 25 MHz controller clock
// Notes:   offsets are the register addresses as seen by the command port
package frp_pkg;

  localparam int unsigned CLK_HZ = 25_000_000;

  // register addresses
  localparam logic [15:0] FAST_OV_ACTION_ADDR = 16'hfe01;
  localparam logic [15:0] OPEN_LOOP_ACTION_ADDR = 16'hfe02;
  localparam logic [15:0] IO_SUPPLY_ACTION_ADDR = 16'hfe03;
  localparam logic [15:0] CORE_SUPPLY_ACTION_ADDR = 16'hfe04;

  // reset values
  localparam logic [7:0] FAST_OV_ACTION_RST = 8'h00;
  localparam logic [7:0] OPEN_LOOP_ACTION_RST = 8'h00;
  localparam logic [7:0] SUPPLY_ACTION_RST = 8'h00;

  // field positions
  localparam int unsigned RESP_MSB = 7;
  localparam int unsigned RESP_LSB = 6;
  localparam int unsigned SAVE_FLAG_BIT = 6;
  localparam int unsigned RETRY_MSB = 5;
  localparam int unsigned RETRY_LSB = 3;
  localparam int unsigned RELOAD_BIT = 2;
  localparam int unsigned DEBOUNCE_BIT = 1;
  localparam int unsigned IGNORE_BIT = 0;

  // writable bits; everything else reads zero
  localparam logic [7:0] RESP_WMASK = 8'hc0;
  localparam logic [7:0] SUPPLY_WMASK = 8'h7f;

  // timing
  localparam int unsigned RETRY_STEP_MS = 588;
  localparam int unsigned RETRY_STEP_CYC = RETRY_STEP_MS * (CLK_HZ / 1000);
  localparam int unsigned DEB_SHORT_NS = 2560;
  localparam int unsigned DEB_SHORT_CYC = (DEB_SHORT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned DEB_LONG_US = 660;
  localparam int unsigned DEB_LONG_CYC = DEB_LONG_US * (CLK_HZ / 1_000_000);

  typedef enum logic [1:0] {
    FRP_RESP_IGNORE   = 2'h0,
    FRP_RESP_RESTART  = 2'h1,
    FRP_RESP_WAIT_PON = 2'h2,
    FRP_RESP_HOLD     = 2'h3
  } frp_resp_t;

endpackage : frp_pkg

// file: rtl/frp_debounce.sv
// Purpose: qualify a supply overvoltage level over a selectable time
// Assumes: fault input synchronous to clk_i
// Notes:   output rises only after the input stays high for the chosen count
`timescale 1ns/1ps
module frp_debounce #(
  parameter int unsigned CNT_W     = 16,
  parameter int unsigned SHORT_CYC = 64,
  parameter int unsigned LONG_CYC  = 16500
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  // control
  input  wire logic short_sel_i,
  input  wire logic fault_i,
  // result
  output logic      fault_o
);

  // refuse counts the counter cannot reach
  if (LONG_CYC >= (1 << CNT_W) || SHORT_CYC >= (1 << CNT_W) || SHORT_CYC == 0) begin : g_bad_cnt
    $error("frp_debounce: counts do not fit CNT_W");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             flt;
  } frp_deb_state_t;

  frp_deb_state_t st_q;
  frp_deb_state_t st_d;
  logic [CNT_W-1:0] limit;

  always_comb begin
    st_d  = st_q;
    limit = short_sel_i ? CNT_W'(SHORT_CYC) : CNT_W'(LONG_CYC);
    if (!fault_i) begin
      st_d.cnt = '0;
      st_d.flt = 1'b0;
    end else if (st_q.cnt + CNT_W'(1) >= limit) begin
      st_d.flt = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign fault_o = st_q.flt;

endmodule : frp_debounce

// file: rtl/frp_fault_policy.sv
// Purpose: hold the fault action registers and apply them to the converter
// Assumes: register port and fault inputs synchronous to clk_i
// Notes:   detection, soft start and EEPROM engines sit outside this block
`timescale 1ns/1ps
module frp_fault_policy #(
  parameter int unsigned RETRY_STEP_CYC = frp_pkg::RETRY_STEP_CYC,
  parameter int unsigned DEB_SHORT_CYC  = frp_pkg::DEB_SHORT_CYC,
  parameter int unsigned DEB_LONG_CYC   = frp_pkg::DEB_LONG_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // register port
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [15:0] reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic [7:0]       reg_rdata_o,
  output logic             reg_hit_o,
  // fault levels
  input  wire logic        output_overvoltage_fault_i,
  input  wire logic        open_loop_fault_i,
  input  wire logic        io_supply_overvoltage_i,
  input  wire logic        core_supply_overvoltage_i,
  // unlatched fault flags from status logic
  input  wire logic        ov_flag_i,
  input  wire logic        olp_flag_i,
  // power-on request and soft start
  input  wire logic        power_on_request_i,
  input  wire logic        soft_start_done_i,
  // converter control
  output logic             pwm_enable_o,
  output logic             soft_start_o,
  output logic             shutdown_o,
  // EEPROM requests
  output logic             save_first_flag_o,
  output logic             eeprom_reload_o,
  output logic [1:0]       first_flag_id_o
);

  // refuse counts the timers cannot serve
  if (RETRY_STEP_CYC == 0 || DEB_SHORT_CYC == 0 || DEB_LONG_CYC == 0 || DEB_LONG_CYC >= 32'h10000) begin : g_bad_timing
    $error("frp_fault_policy: timing counts out of range");
  end

  localparam int unsigned RW = 35;

  typedef enum logic [2:0] {
    FRP_RUN,
    FRP_START,
    FRP_WAIT_PON,
    FRP_RETRY,
    FRP_HOLD
  } frp_state_t;

  typedef struct packed {
    logic [7:0]    fast_ov;
    logic [7:0]    open_loop_fault;
    logic [7:0]    io_sup;
    logic [7:0]    core_sup;
    frp_state_t    fsm;
    logic [RW-1:0] retry_cnt;
    logic          hold_ov;
    logic          hold_olp;
    logic          pon_seen_low;
    logic [7:0]    rdata;
    logic          save;
    logic          reload;
    logic [1:0]    flag_id;
  } frp_state_s_t;

  frp_state_s_t st_q;
  frp_state_s_t st_d;

  logic io_ov;
  logic core_ov;

  frp_debounce #(
    .CNT_W     (16),
    .SHORT_CYC (DEB_SHORT_CYC),
    .LONG_CYC  (DEB_LONG_CYC)
  ) u_deb_io (
    .clk_i       (clk_i),
    .arst_n_i    (arst_n_i),
    .short_sel_i (st_q.io_sup[frp_pkg::DEBOUNCE_BIT]),
    .fault_i     (io_supply_overvoltage_i),
    .fault_o     (io_ov)
  );

  frp_debounce #(
    .CNT_W     (16),
    .SHORT_CYC (DEB_SHORT_CYC),
    .LONG_CYC  (DEB_LONG_CYC)
  ) u_deb_core (
    .clk_i       (clk_i),
    .arst_n_i    (arst_n_i),
    .short_sel_i (st_q.core_sup[frp_pkg::DEBOUNCE_BIT]),
    .fault_i     (core_supply_overvoltage_i),
    .fault_o     (core_ov)
  );

  function automatic frp_pkg::frp_resp_t resp_of(input logic [7:0] r);
    resp_of = frp_pkg::frp_resp_t'(r[frp_pkg::RESP_MSB:frp_pkg::RESP_LSB]);
  endfunction : resp_of

  function automatic logic [RW-1:0] wait_of(input logic [7:0] r);
    wait_of = RW'(r[frp_pkg::RETRY_MSB:frp_pkg::RETRY_LSB]) * RW'(RETRY_STEP_CYC);
  endfunction : wait_of

  frp_pkg::frp_resp_t ov_resp;
  frp_pkg::frp_resp_t olp_resp;
  logic               ov_act;
  logic               olp_act;
  logic               io_act;
  logic               core_act;

  always_comb begin
    st_d        = st_q;
    st_d.save   = 1'b0;
    st_d.reload = 1'b0;
    ov_resp     = resp_of(st_q.fast_ov);
    olp_resp    = resp_of(st_q.open_loop_fault);
    ov_act      = output_overvoltage_fault_i && ov_resp != frp_pkg::FRP_RESP_IGNORE;
    olp_act     = open_loop_fault_i && olp_resp != frp_pkg::FRP_RESP_IGNORE;
    io_act      = io_ov && !st_q.io_sup[frp_pkg::IGNORE_BIT];
    core_act    = core_ov && !st_q.core_sup[frp_pkg::IGNORE_BIT];

    if (reg_wr_i) begin
      case (reg_addr_i)
        frp_pkg::FAST_OV_ACTION_ADDR: st_d.fast_ov = reg_wdata_i & frp_pkg::RESP_WMASK;
        frp_pkg::OPEN_LOOP_ACTION_ADDR: st_d.open_loop_fault = reg_wdata_i & frp_pkg::RESP_WMASK;
        frp_pkg::IO_SUPPLY_ACTION_ADDR: st_d.io_sup = reg_wdata_i & frp_pkg::SUPPLY_WMASK;
        frp_pkg::CORE_SUPPLY_ACTION_ADDR: st_d.core_sup = reg_wdata_i & frp_pkg::SUPPLY_WMASK;
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        frp_pkg::FAST_OV_ACTION_ADDR: st_d.rdata = st_q.fast_ov;
        frp_pkg::OPEN_LOOP_ACTION_ADDR: st_d.rdata = st_q.open_loop_fault;
        frp_pkg::IO_SUPPLY_ACTION_ADDR: st_d.rdata = st_q.io_sup;
        frp_pkg::CORE_SUPPLY_ACTION_ADDR: st_d.rdata = st_q.core_sup;
        default: st_d.rdata = 8'h00;
      endcase
    end

    // hold latches set, release on flag clear
    if (ov_act && ov_resp == frp_pkg::FRP_RESP_HOLD) begin
      st_d.hold_ov = 1'b1;
    end else if (!ov_flag_i) begin
      st_d.hold_ov = 1'b0;
    end
    if (olp_act && olp_resp == frp_pkg::FRP_RESP_HOLD) begin
      st_d.hold_olp = 1'b1;
    end else if (!olp_flag_i) begin
      st_d.hold_olp = 1'b0;
    end

    case (st_q.fsm)
      FRP_RUN, FRP_START: begin
        if (io_act || core_act) begin
          // supply faults: retry after programmed wait
          if (io_act) begin
            st_d.save      = st_q.io_sup[frp_pkg::SAVE_FLAG_BIT];
            st_d.reload    = st_q.io_sup[frp_pkg::RELOAD_BIT];
            st_d.flag_id   = 2'h2;
            st_d.retry_cnt = wait_of(st_q.io_sup);
          end else begin
            st_d.save      = st_q.core_sup[frp_pkg::SAVE_FLAG_BIT];
            st_d.reload    = st_q.core_sup[frp_pkg::RELOAD_BIT];
            st_d.flag_id   = 2'h3;
            st_d.retry_cnt = wait_of(st_q.core_sup);
          end
          st_d.fsm = FRP_RETRY;
        end else if ((ov_act && ov_resp == frp_pkg::FRP_RESP_WAIT_PON)
                     || (olp_act && olp_resp == frp_pkg::FRP_RESP_WAIT_PON)) begin
          st_d.flag_id      = (ov_act && ov_resp == frp_pkg::FRP_RESP_WAIT_PON) ? 2'h0 : 2'h1;
          st_d.pon_seen_low = 1'b0;
          st_d.fsm          = FRP_WAIT_PON;
        end else if ((ov_act && ov_resp == frp_pkg::FRP_RESP_RESTART)
                     || (olp_act && olp_resp == frp_pkg::FRP_RESP_RESTART)) begin
          st_d.flag_id = (ov_act && ov_resp == frp_pkg::FRP_RESP_RESTART) ? 2'h0 : 2'h1;
          st_d.fsm     = FRP_START;
        end else if (st_q.fsm == FRP_START && soft_start_done_i) begin
          st_d.fsm = FRP_RUN;
        end
      end
      FRP_WAIT_PON: begin
        // restart only on a fresh assertion
        if (!power_on_request_i) begin
          st_d.pon_seen_low = 1'b1;
        end else if (st_q.pon_seen_low) begin
          st_d.fsm = FRP_START;
        end
      end
      FRP_RETRY: begin
        if (st_q.retry_cnt == '0) begin
          st_d.fsm = FRP_START;
        end else begin
          st_d.retry_cnt = st_q.retry_cnt - RW'(1);
        end
      end
      default: st_d.fsm = FRP_RUN;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q          <= '0;
      st_q.fast_ov  <= frp_pkg::FAST_OV_ACTION_RST;
      st_q.open_loop_fault      <= frp_pkg::OPEN_LOOP_ACTION_RST;
      st_q.io_sup   <= frp_pkg::SUPPLY_ACTION_RST;
      st_q.core_sup <= frp_pkg::SUPPLY_ACTION_RST;
      st_q.fsm      <= FRP_START;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_hit_o = reg_addr_i >= frp_pkg::FAST_OV_ACTION_ADDR
                     && reg_addr_i <= frp_pkg::CORE_SUPPLY_ACTION_ADDR;
  assign reg_rdata_o       = st_q.rdata;
  assign shutdown_o        = st_q.fsm == FRP_WAIT_PON || st_q.fsm == FRP_RETRY;
  assign soft_start_o      = st_q.fsm == FRP_START;
  assign pwm_enable_o      = !shutdown_o && !st_q.hold_ov && !st_q.hold_olp;
  assign save_first_flag_o = st_q.save;
  assign eeprom_reload_o   = st_q.reload;
  assign first_flag_id_o   = st_q.flag_id;

endmodule : frp_fault_policy

// file: tb/frp_plant_model.sv
// Purpose: converter side model ending soft start and giving fault flags
// Assumes: slow_i picks a long soft start and slow flag clearing
// Notes:   flags are unlatched copies of the fault levels, lagging them
`timescale 1ns/1ps
module frp_plant_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  // converter side
  input  wire logic       slow_i,
  input  wire logic       soft_start_i,
  input  wire logic [1:0] fault_i,
  // answers
  output logic            done_o,
  output logic [1:0]      flag_o
);
  logic [4:0] cnt_q;
  logic [3:0] ov_q;
  logic [3:0] ol_q;
  assign flag_o = slow_i ? {|ol_q, |ov_q} : {ol_q[0], ov_q[0]};
  assign done_o = soft_start_i && (cnt_q >= (slow_i ? 5'h1e : 5'h03));
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= 5'h00;
      ov_q  <= 4'h0;
      ol_q  <= 4'h0;
    end else begin
      ov_q <= {ov_q[2:0], fault_i[0]};
      ol_q <= {ol_q[2:0], fault_i[1]};
      if (!soft_start_i) cnt_q <= 5'h00;
      else if (cnt_q != 5'h1f) cnt_q <= cnt_q + 5'h01;
    end
  end
endmodule : frp_plant_model

// file: tb/frp_fault_policy_checker.sv
// Purpose: port checker for the fault response policy block
// Assumes: settings change only through port writes
// Notes:   action fields are shadowed from the writes seen
`timescale 1ns/1ps
module frp_fault_policy_checker #(
  parameter int unsigned RETRY_STEP_CYC = frp_pkg::RETRY_STEP_CYC,
  parameter int unsigned DEB_SHORT_CYC  = frp_pkg::DEB_SHORT_CYC,
  parameter int unsigned DEB_LONG_CYC   = frp_pkg::DEB_LONG_CYC
) (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  // register port
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic        reg_hit_o,
  // faults and control
  input wire logic        output_overvoltage_fault_i,
  input wire logic        open_loop_fault_i,
  input wire logic        pwm_enable_o,
  input wire logic        soft_start_o,
  input wire logic        shutdown_o,
  input wire logic        save_first_flag_o,
  input wire logic        eeprom_reload_o
);
  logic [1:0] fov_q;
  logic [1:0] olp_q;
  logic [6:0] io_q;
  logic [6:0] core_q;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fov_q  <= 2'h0;
      olp_q  <= 2'h0;
      io_q   <= 7'h00;
      core_q <= 7'h00;
    end else if (reg_wr_i) begin
      if (reg_addr_i == frp_pkg::FAST_OV_ACTION_ADDR) fov_q <= reg_wdata_i[7:6];
      if (reg_addr_i == frp_pkg::OPEN_LOOP_ACTION_ADDR) olp_q <= reg_wdata_i[7:6];
      if (reg_addr_i == frp_pkg::IO_SUPPLY_ACTION_ADDR) io_q <= reg_wdata_i[6:0];
      if (reg_addr_i == frp_pkg::CORE_SUPPLY_ACTION_ADDR) core_q <= reg_wdata_i[6:0];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence fast_hit(logic [1:0] c);
    output_overvoltage_fault_i && fov_q == c;
  endsequence
  sequence olp_hit(logic [1:0] c);
    open_loop_fault_i && !output_overvoltage_fault_i && olp_q == c;
  endsequence
  rd_unmapped_a: assert property ($past(reg_rd_i) && !$past(reg_hit_o) |-> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  rd_reserved_a: assert property ($past(reg_rd_i) && ($past(reg_addr_i) == frp_pkg::FAST_OV_ACTION_ADDR ||
    $past(reg_addr_i) == frp_pkg::OPEN_LOOP_ACTION_ADDR) |-> reg_rdata_o[5:0] == 6'h00)
    else $error("reserved response bits set");
  rd_fast_a: assert property ($past(reg_rd_i) && !$past(reg_wr_i) &&
    $past(reg_addr_i) == frp_pkg::FAST_OV_ACTION_ADDR |-> reg_rdata_o[7:6] == fov_q)
    else $error("fast response field wrong");
  hold_off_a: assert property (fast_hit(2'h3) |-> ##[1:2] !pwm_enable_o)
    else $error("pwm not held off");
  pon_wait_a: assert property (olp_hit(2'h2) |-> ##[1:2] shutdown_o)
    else $error("no shutdown on open loop");
  restart_ss_a: assert property (fast_hit(2'h1) ##0 !shutdown_o |-> ##[1:2] soft_start_o)
    else $error("no soft start after fault");
  save_sel_a: assert property (save_first_flag_o |-> io_q[6] || core_q[6])
    else $error("flag saved while disabled");
  reload_sel_a: assert property (eeprom_reload_o |-> io_q[2] || core_q[2])
    else $error("reload while disabled");
  pulse_len_a: assert property (save_first_flag_o || eeprom_reload_o |=> !save_first_flag_o && !eeprom_reload_o)
    else $error("request pulse too long");
endmodule : frp_fault_policy_checker

bind frp_fault_policy frp_fault_policy_checker #(
  .RETRY_STEP_CYC(RETRY_STEP_CYC),
  .DEB_SHORT_CYC (DEB_SHORT_CYC),
  .DEB_LONG_CYC  (DEB_LONG_CYC)
) chk_u (.clk_i, .arst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_hit_o,
  .output_overvoltage_fault_i, .open_loop_fault_i, .pwm_enable_o, .soft_start_o, .shutdown_o,
  .save_first_flag_o, .eeprom_reload_o);

// file: tb/frp_fault_policy_tb_top.sv
// Purpose: self-checking bench for the fault response policy block
// Assumes: retry and debounce counts shortened by parameters
// Notes:   read data checked by a queue-fed watcher
`timescale 1ns/1ps
module frp_fault_policy_tb_top;
  localparam int unsigned RS = 10;
  localparam int unsigned DS = 4;
  localparam int unsigned DL = 20;
  localparam logic [15:0] FA = frp_pkg::FAST_OV_ACTION_ADDR;
  localparam logic [15:0] OA = frp_pkg::OPEN_LOOP_ACTION_ADDR;
  localparam logic [15:0] IA = frp_pkg::IO_SUPPLY_ACTION_ADDR;
  localparam logic [15:0] CA = frp_pkg::CORE_SUPPLY_ACTION_ADDR;
  logic        clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wd = 8'h00;
  logic [3:0]  flt = 4'h0;
  logic        pon = 1'b1;
  logic        slow = 1'b0;
  logic [7:0]  rdat;
  logic [1:0]  flag;
  logic [1:0]  fid;
  logic [1:0]  id_seen;
  logic        done, pwm, ss, sd, save, reload, rd_seen;
  logic [7:0]  exp_q[$];
  logic [15:0] adr[4] = '{FA, OA, IA, CA};
  logic [7:0]  msk[4] = '{frp_pkg::RESP_WMASK, frp_pkg::RESP_WMASK, frp_pkg::SUPPLY_WMASK, frp_pkg::SUPPLY_WMASK};
  int          err_total = 0, num_checks = 0, n_save = 0, n_reload = 0, cyc = 0;

  initial forever #20 clk_i = ~clk_i;

  frp_fault_policy #(.RETRY_STEP_CYC(RS), .DEB_SHORT_CYC(DS), .DEB_LONG_CYC(DL)) dut_u (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_rdata_o(rdat), .reg_hit_o(), .output_overvoltage_fault_i(flt[0]),
    .open_loop_fault_i(flt[1]), .io_supply_overvoltage_i(flt[2]), .core_supply_overvoltage_i(flt[3]),
    .ov_flag_i(flag[0]), .olp_flag_i(flag[1]), .power_on_request_i(pon), .soft_start_done_i(done),
    .pwm_enable_o(pwm), .soft_start_o(ss), .shutdown_o(sd), .save_first_flag_o(save),
    .eeprom_reload_o(reload), .first_flag_id_o(fid));
  frp_plant_model pm_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .slow_i(slow), .soft_start_i(ss),
    .fault_i(flt[1:0]), .done_o(done), .flag_o(flag));

  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : cmp8
  task automatic cmp1(input logic g, input logic e);
    cmp8({7'h00, g}, {7'h00, e});
  endtask : cmp1
  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr   <= 1'b1;
    addr <= a;
    wd   <= d;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_i);
    rd   <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    @(posedge clk_i);
    rd <= 1'b0;
  endtask : rreg
  task automatic pulse(input int i, input int n);
    @(posedge clk_i) flt[i] <= 1'b1;
    repeat (n) @(posedge clk_i);
    flt[i] <= 1'b0;
  endtask : pulse
  task automatic settle();
    for (int k = 0; k < 80 && (ss || sd); k++) @(negedge clk_i);
    cmp1(ss | sd, 1'b0);
  endtask : settle
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  always @(posedge clk_i) begin
    if (rd_seen) cmp8(rdat, exp_q.pop_front());
    rd_seen <= rd;
    if (save) n_save++;
    if (save) id_seen = fid;
    if (reload) n_reload++;
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      wrap_up();
    end
  end

  initial begin
    int n;
    void'($urandom(32'ha4c721e2));
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    foreach (adr[i]) rreg(adr[i], 8'h00);
    foreach (adr[i]) wreg(adr[i], 8'hff);
    foreach (adr[i]) rreg(adr[i], msk[i]);
    wreg(16'hfe05, 8'hff);
    rreg(16'hfe05, 8'h00);
    n = $urandom;
    wreg(IA, 8'(n));
    rreg(IA, 8'(n) & frp_pkg::SUPPLY_WMASK);
    $display("test registers done");
    wreg(FA, 8'h00);
    wreg(OA, 8'h00);
    @(posedge clk_i) flt[1:0] <= 2'h3;
    repeat (4) @(negedge clk_i);
    cmp1(pwm & !sd & !ss, 1'b1);
    @(posedge clk_i) flt[1:0] <= 2'h0;
    $display("test ignore done");
    wreg(OA, 8'h80);
    pulse(1, 2);
    repeat (6) @(negedge clk_i);
    cmp1(sd & !ss, 1'b1);
    @(posedge clk_i) pon <= 1'b0;
    @(posedge clk_i) pon <= 1'b1;
    repeat (3) @(negedge clk_i);
    cmp1(ss, 1'b1);
    settle();
    $display("test power-on wait done");
    slow <= 1'b1;
    wreg(FA, 8'h40);
    pulse(0, 1);
    repeat (2) @(negedge clk_i);
    cmp1(ss & !sd, 1'b1);
    repeat (10) @(negedge clk_i);
    cmp1(ss, 1'b1);
    settle();
    $display("test restart done");
    wreg(FA, 8'hc0);
    @(posedge clk_i) flt[0] <= 1'b1;
    repeat (3) @(negedge clk_i);
    cmp1(pwm, 1'b0);
    @(posedge clk_i) flt[0] <= 1'b0;
    repeat (2) @(negedge clk_i);
    cmp1(pwm, 1'b0);
    repeat (10) @(negedge clk_i);
    cmp1(pwm, 1'b1);
    slow <= 1'b0;
    wreg(OA, 8'hc0);
    pulse(1, 1);
    @(negedge clk_i);
    cmp1(pwm, 1'b0);
    repeat (6) @(negedge clk_i);
    cmp1(pwm, 1'b1);
    $display("test hold done");
    wreg(FA, 8'h00);
    wreg(CA, 8'h01);
    wreg(IA, 8'h56);
    pulse(2, DS + 2);
    for (n = 0; n < 20 && !sd; n++) @(negedge clk_i);
    for (n = 0; n < 60 && sd; n++) @(negedge clk_i);
    cmp1(n >= 2 * RS && n <= 2 * RS + 3, 1'b1);
    cmp1(ss, 1'b1);
    cmp8(8'(n_save), 8'h01);
    cmp8(8'(n_reload), 8'h01);
    cmp8({6'h00, id_seen}, 8'h02);
    settle();
    $display("test io supply done");
    wreg(IA, 8'h01);
    wreg(CA, 8'h08);
    pulse(3, DL / 2);
    repeat (4) @(negedge clk_i);
    cmp1(sd, 1'b0);
    pulse(3, DL + 4);
    @(negedge clk_i);
    cmp1(sd, 1'b1);
    settle();
    cmp8(8'(n_save), 8'h01);
    cmp8(8'(n_reload), 8'h01);
    $display("test core supply done");
    wreg(IA, 8'h03);
    wreg(CA, 8'h03);
    @(posedge clk_i) flt[3:2] <= 2'h3;
    repeat (10) @(negedge clk_i);
    cmp1(sd | ss | !pwm, 1'b0);
    @(posedge clk_i) flt[3:2] <= 2'h0;
    $display("test supply ignore done");
    wrap_up();
  end
endmodule : frp_fault_policy_tb_top
